// ===== shared/pocs_pkg.sv
// Summary of operation
// - Standby on pin toggle, I2C or JTAG
// - Standby keeps config, logic, I/Os alive
// - Selected subsystems power down on standby
// - Both supplies rising starts flash download
// - I/Os tristated before and during configuration
// - I/Os released only in user mode
// - Regulated variant also gates on the outer rail
// - Enabled droop in user mode resets
// - Continued monitoring is an option
// - Bandgap off leaves low-power monitor only
// - Non-regulated bandgap off only in user
// - Selected port stays active until cycle end
// - JTAG activation accepted any time
// - Optional CRC check on user entry
// - Serial config pins become GPIO when free
// - Test pins GPIO under test port select
// - Security bits block readback
// - Only full erase clears security bits
// - OTP rejects every erase and reprogram
// - Five configuration methods
// - Wake outputs only when wakeup enabled
package pocs_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS        = 4;
	localparam int FLASH_DOWNLOAD_US    = 2;
	localparam int FLASH_DOWNLOAD_CYC   = (FLASH_DOWNLOAD_US * 1000) / CLK_PERIOD_NS;
	localparam int CRC_CHECK_CYC        = 64;
	localparam int CNT_W                = 16;

	// ****************************************
	// Configuration sources
	// ****************************************
	typedef enum logic [2:0]
	{
		POCS_SRC_FLASH,
		POCS_SRC_JTAG,
		POCS_SRC_MSPI,
		POCS_SRC_SLAVE_SERIAL,
		POCS_SRC_I2C
	} pocs_src_t;

	localparam logic [2:0] SRC_RST = 3'h0;

endpackage : pocs_pkg

// ===== verilog/pocs_top.sv
`timescale 1ns/1ps
module pocs_top
(
	// Clock and reset
	input  wire logic               core_clk_i,
	input  wire logic               rst_i,
	// Supply monitor comparators
	input  wire logic               core_supply_ok_i,
	input  wire logic               bank0_supply_ok_i,
	input  wire logic               ext_supply_ok_i,
	input  wire logic               core_above_precise_i,
	input  wire logic               core_above_lowpower_i,
	// Static options
	input  wire logic               regulated_variant_i,
	input  wire logic               monitor_keep_en_i,
	input  wire logic               crc_check_en_i,
	input  wire logic               wakeup_en_i,
	input  wire logic               bandgap_off_on_stby_i,
	input  wire logic               monitor_off_on_stby_i,
	input  wire logic               bandgap_off_req_i,
	// Standby triggers
	input  wire logic               stby_pin_i,
	input  wire logic               stby_i2c_i,
	input  wire logic               stby_jtag_i,
	input  wire logic               wake_i,
	// Configuration sources
	input  wire logic               src_req_i,
	input  wire pocs_pkg::pocs_src_t src_sel_i,
	input  wire logic               jtag_activate_i,
	input  wire logic               cfg_load_done_i,
	input  wire logic               crc_ok_i,
	input  wire logic               test_port_select_i,
	// Security and OTP
	input  wire logic               sec_set_i,
	input  wire logic               otp_set_i,
	input  wire logic               erase_req_i,
	input  wire logic               prog_req_i,
	input  wire logic               readback_req_i,
	// Outputs
	output logic                    flash_download_o,
	output logic                    io_tristate_o,
	output logic                    user_mode_o,
	output logic                    user_rst_o,
	output logic                    stby_o,
	output logic                    bandgap_on_o,
	output logic                    precise_mon_on_o,
	output logic                    cfg_port_active_o,
	output pocs_pkg::pocs_src_t     cfg_src_o,
	output logic                    jtag_active_o,
	output logic                    serial_cfg_gpio_o,
	output logic                    tap_gpio_o,
	output logic                    crc_error_o,
	output logic                    sec_locked_o,
	output logic                    otp_locked_o,
	output logic                    readback_grant_o,
	output logic                    erase_grant_o,
	output logic                    prog_grant_o,
	output logic                    cfg_stdby_o,
	output logic                    cfg_wake_o
);
	import pocs_pkg::*;

	// ****************************************
	// Main sequencer
	// ****************************************
	typedef enum logic [2:0] {ST_MON, ST_LOAD, ST_CRC, ST_USER, ST_FAIL} pocs_state_t;

	pocs_state_t              state_ff, nxt_state;
	logic [CNT_W-1:0]         cnt_ff, nxt_cnt;
	logic                     stby_ff, nxt_stby;
	logic                     bg_ff, nxt_bg;
	logic                     pin_q_ff;
	logic                     port_ff, nxt_port;
	pocs_src_t                src_ff, nxt_src;
	logic                     jtag_ff, nxt_jtag;
	logic                     crcerr_ff, nxt_crcerr;
	logic                     sec_ff, nxt_sec;
	logic                     otp_ff, nxt_otp;
	logic                     supplies_ok, droop, stby_trig;

	// Start-up needs every monitored rail; regulated parts add the outer rail
	assign supplies_ok = core_supply_ok_i & bank0_supply_ok_i
		& (~regulated_variant_i | ext_supply_ok_i);
	// Low-power monitor is coarser: it only sees the lower trip point
	assign droop = monitor_keep_en_i
		& (bg_ff ? ~core_above_precise_i : ~core_above_lowpower_i);
	assign stby_trig = (stby_pin_i ^ pin_q_ff) | stby_i2c_i | stby_jtag_i;

	// Next-state logic
	always_comb
	begin
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_stby   = stby_ff;
		nxt_bg     = bg_ff;
		nxt_port   = port_ff;
		nxt_src    = src_ff;
		nxt_jtag   = jtag_ff | jtag_activate_i;
		nxt_crcerr = crcerr_ff;
		nxt_sec    = sec_ff | sec_set_i;
		nxt_otp    = otp_ff | otp_set_i;
		// Erase is the only path that clears the security bit; OTP blocks even that
		if (erase_req_i && !otp_ff)
		begin
			nxt_sec = sec_set_i;
		end
		case (state_ff)
			ST_MON:
			begin
				nxt_cnt  = '0;
				nxt_port = 1'b0;
				nxt_bg   = 1'b1;
				nxt_stby = 1'b0;
				if (supplies_ok)
				begin
					nxt_state = ST_LOAD;
					nxt_port  = 1'b1;
					nxt_src   = POCS_SRC_FLASH;
				end
			end
			ST_LOAD:
			begin
				// A port once chosen holds until the cycle ends
				if (src_req_i && src_ff == POCS_SRC_FLASH && cnt_ff == '0)
				begin
					nxt_src = src_sel_i;
				end
				if (cnt_ff != CNT_W'(FLASH_DOWNLOAD_CYC))
				begin
					nxt_cnt = cnt_ff + 1'b1;
				end
				if (cfg_load_done_i && cnt_ff == CNT_W'(FLASH_DOWNLOAD_CYC))
				begin
					nxt_cnt   = '0;
					nxt_port  = 1'b0;
					nxt_state = crc_check_en_i ? ST_CRC : ST_USER;
				end
			end
			ST_CRC:
			begin
				nxt_cnt = cnt_ff + 1'b1;
				if (cnt_ff == CNT_W'(CRC_CHECK_CYC))
				begin
					nxt_crcerr = ~crc_ok_i;
					nxt_state  = crc_ok_i ? ST_USER : ST_FAIL;
				end
			end
			ST_USER:
			begin
				// Bandgap may drop only in user mode, and only on request
				if (bandgap_off_req_i)
				begin
					nxt_bg = 1'b0;
				end
				if (stby_trig && !stby_ff)
				begin
					nxt_stby = 1'b1;
				end
				else if (wake_i)
				begin
					nxt_stby = 1'b0;
				end
				// Droop wins over a bandgap-off request: monitoring restarts precise
				if (droop)
				begin
					nxt_state = ST_MON;
					nxt_bg    = 1'b1;
				end
			end
			default:
			begin
				if (!supplies_ok)
				begin
					nxt_state = ST_MON;
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_ff  <= ST_MON;
			cnt_ff    <= '0;
			stby_ff   <= 1'b0;
			bg_ff     <= 1'b1;
			pin_q_ff  <= 1'b0;
			port_ff   <= 1'b0;
			src_ff    <= pocs_src_t'(SRC_RST);
			jtag_ff   <= 1'b0;
			crcerr_ff <= 1'b0;
			sec_ff    <= 1'b0;
			otp_ff    <= 1'b0;
		end
		else
		begin
			state_ff  <= nxt_state;
			cnt_ff    <= nxt_cnt;
			stby_ff   <= nxt_stby;
			bg_ff     <= nxt_bg;
			pin_q_ff  <= stby_pin_i;
			port_ff   <= nxt_port;
			src_ff    <= nxt_src;
			jtag_ff   <= nxt_jtag;
			crcerr_ff <= nxt_crcerr;
			sec_ff    <= nxt_sec;
			otp_ff    <= nxt_otp;
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			flash_download_o  <= 1'b0;
			io_tristate_o     <= 1'b1;
			user_mode_o       <= 1'b0;
			user_rst_o        <= 1'b1;
			stby_o            <= 1'b0;
			bandgap_on_o      <= 1'b1;
			precise_mon_on_o  <= 1'b1;
			cfg_port_active_o <= 1'b0;
			cfg_src_o         <= pocs_src_t'(SRC_RST);
			jtag_active_o     <= 1'b0;
			serial_cfg_gpio_o <= 1'b0;
			tap_gpio_o        <= 1'b0;
			crc_error_o       <= 1'b0;
			sec_locked_o      <= 1'b0;
			otp_locked_o      <= 1'b0;
			readback_grant_o  <= 1'b0;
			erase_grant_o     <= 1'b0;
			prog_grant_o      <= 1'b0;
			cfg_stdby_o       <= 1'b0;
			cfg_wake_o        <= 1'b0;
		end
		else
		begin
			flash_download_o  <= nxt_state == ST_LOAD && nxt_src == POCS_SRC_FLASH;
			io_tristate_o     <= nxt_state != ST_USER;
			user_mode_o       <= nxt_state == ST_USER;
			// Single synchronous release so all user flops leave reset together
			user_rst_o        <= nxt_state != ST_USER;
			// Standby leaves logic and I/Os running; only opted-in parts sleep
			stby_o            <= nxt_stby;
			bandgap_on_o      <= nxt_bg & ~(nxt_stby & bandgap_off_on_stby_i);
			precise_mon_on_o  <= nxt_bg & ~(nxt_stby & (bandgap_off_on_stby_i
				| monitor_off_on_stby_i));
			cfg_port_active_o <= nxt_port;
			cfg_src_o         <= nxt_src;
			jtag_active_o     <= nxt_jtag;
			serial_cfg_gpio_o <= nxt_state == ST_USER && nxt_src != POCS_SRC_SLAVE_SERIAL;
			// Select pin governs the test pins, but a loading test port keeps them
			tap_gpio_o        <= ~test_port_select_i
				& ~(nxt_port && nxt_src == POCS_SRC_JTAG);
			crc_error_o       <= nxt_crcerr;
			sec_locked_o      <= nxt_sec;
			otp_locked_o      <= nxt_otp;
			readback_grant_o  <= readback_req_i & ~sec_ff;
			erase_grant_o     <= erase_req_i & ~otp_ff;
			prog_grant_o      <= prog_req_i & ~otp_ff;
			cfg_stdby_o       <= wakeup_en_i & stby_trig & (state_ff == ST_USER);
			cfg_wake_o        <= wakeup_en_i & wake_i & stby_ff;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_user_seen;
		user_mode_o;
	endsequence

	AST_IO_TRISTATE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!user_mode_o |-> io_tristate_o)
		else $error("I/O driven outside user mode");
	AST_IO_RELEASE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_user_seen |-> !io_tristate_o && !user_rst_o)
		else $error("I/O or reset not released in user mode");
	AST_START: assert property (@(posedge core_clk_i) disable iff (rst_i)
		state_ff == ST_MON && supplies_ok |=> flash_download_o)
		else $error("Download did not start");
	AST_DROOP: assert property (@(posedge core_clk_i) disable iff (rst_i)
		state_ff == ST_USER && droop |=> !user_mode_o && state_ff == ST_MON)
		else $error("Droop did not reset");
	AST_OTP: assert property (@(posedge core_clk_i) disable iff (rst_i)
		otp_ff |=> !erase_grant_o && !prog_grant_o)
		else $error("OTP part granted erase");
	AST_SEC: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sec_ff && readback_req_i |=> !readback_grant_o)
		else $error("Locked part granted readback");
	AST_SEC_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sec_ff && !erase_req_i |=> sec_ff)
		else $error("Security bit cleared without erase");
	AST_PORT_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
		state_ff == ST_LOAD && cnt_ff != '0 |=> src_ff == $past(src_ff))
		else $error("Configuration port changed mid cycle");
	AST_WAKE_EN: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!wakeup_en_i |=> !cfg_stdby_o && !cfg_wake_o)
		else $error("Wake outputs without enable");
	AST_BG_USER: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!bg_ff |-> state_ff == ST_USER)
		else $error("Bandgap off outside user mode");

endmodule : pocs_top

// ===== tb/pocs_rail_model.sv
`timescale 1ns/1ps
module pocs_rail_model
#(
	parameter int LOAD_CYC = 40
)
(
	// Clock, reset and bench controls
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic rails_up_i,
	input  wire logic droop_i,
	input  wire logic ext_down_i,
	input  wire logic crc_bad_i,
	input  wire logic download_i,
	// Rail comparators and configuration memory
	output logic      core_ok_o,
	output logic      bank0_ok_o,
	output logic      ext_ok_o,
	output logic      above_precise_o,
	output logic      above_lowpower_o,
	output logic      load_done_o,
	output logic      crc_ok_o
);
	logic [7:0] load_cnt_ff;

	// A droop only sinks the core rail, past both falling trips at once
	assign core_ok_o        = rails_up_i & ~droop_i;
	assign bank0_ok_o       = rails_up_i;
	// Outer rail of a regulated part can lag behind the others
	assign ext_ok_o         = rails_up_i & ~ext_down_i;
	assign above_precise_o  = rails_up_i & ~droop_i;
	assign above_lowpower_o = rails_up_i & ~droop_i;
	assign crc_ok_o         = ~crc_bad_i;

	// Flash array needs its own read time; done holds only while reading
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			load_cnt_ff <= 8'h00;
		else if (!download_i)
			load_cnt_ff <= 8'h00;
		else if (load_cnt_ff < LOAD_CYC)
			load_cnt_ff <= load_cnt_ff + 8'h01;
	end
	assign load_done_o = (load_cnt_ff == LOAD_CYC);
endmodule : pocs_rail_model

// ===== tb/test_pocs_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch %s exp %0h got %0h", nm, e, g); end end
module test_pocs_top;
	import pocs_pkg::*;
	logic core_clk_i, rst_i, rails_up, droop, core_supply_ok_i, bank0_supply_ok_i;
	logic ext_down, crc_bad;
	logic ext_supply_ok_i, core_above_precise_i, core_above_lowpower_i, cfg_load_done_i;
	logic crc_ok_i, regulated_variant_i, monitor_keep_en_i, crc_check_en_i, wakeup_en_i;
	logic bandgap_off_on_stby_i, monitor_off_on_stby_i, bandgap_off_req_i, stby_pin_i;
	logic stby_i2c_i, stby_jtag_i, wake_i, src_req_i, jtag_activate_i, test_port_select_i;
	logic sec_set_i, otp_set_i, erase_req_i, prog_req_i, readback_req_i;
	logic flash_download_o, io_tristate_o, user_mode_o, user_rst_o, stby_o, bandgap_on_o;
	logic precise_mon_on_o, cfg_port_active_o, jtag_active_o, serial_cfg_gpio_o, tap_gpio_o;
	logic crc_error_o, sec_locked_o, otp_locked_o, readback_grant_o, erase_grant_o;
	logic prog_grant_o, cfg_stdby_o, cfg_wake_o;
	pocs_src_t src_sel_i, cfg_src_o;
	int n_fail, samples_checked;

	pocs_rail_model pocs_rail_model_i (.core_clk_i, .rst_i, .rails_up_i(rails_up),
		.droop_i(droop), .ext_down_i(ext_down), .crc_bad_i(crc_bad),
		.download_i(flash_download_o), .core_ok_o(core_supply_ok_i),
		.bank0_ok_o(bank0_supply_ok_i), .ext_ok_o(ext_supply_ok_i),
		.above_precise_o(core_above_precise_i), .above_lowpower_o(core_above_lowpower_i),
		.load_done_o(cfg_load_done_i), .crc_ok_o(crc_ok_i));
	pocs_top pocs_top_i (.core_clk_i, .rst_i, .core_supply_ok_i, .bank0_supply_ok_i,
		.ext_supply_ok_i, .core_above_precise_i, .core_above_lowpower_i, .regulated_variant_i,
		.monitor_keep_en_i, .crc_check_en_i, .wakeup_en_i, .bandgap_off_on_stby_i,
		.monitor_off_on_stby_i, .bandgap_off_req_i, .stby_pin_i, .stby_i2c_i, .stby_jtag_i,
		.wake_i, .src_req_i, .src_sel_i, .jtag_activate_i, .cfg_load_done_i, .crc_ok_i,
		.test_port_select_i, .sec_set_i, .otp_set_i, .erase_req_i, .prog_req_i,
		.readback_req_i, .flash_download_o, .io_tristate_o, .user_mode_o, .user_rst_o,
		.stby_o, .bandgap_on_o, .precise_mon_on_o, .cfg_port_active_o, .cfg_src_o,
		.jtag_active_o, .serial_cfg_gpio_o, .tap_gpio_o, .crc_error_o, .sec_locked_o,
		.otp_locked_o, .readback_grant_o, .erase_grant_o, .prog_grant_o, .cfg_stdby_o,
		.cfg_wake_o);

	// ****************************************
	// Scenarios
	// ****************************************
	// Rails up, then watch the whole download; bg also asks for bandgap off and a CRC pass
	task automatic power_up(logic bg);
		int n;
		@(posedge core_clk_i) rails_up <= 1'b1;
		bandgap_off_req_i <= bg;
		crc_check_en_i <= bg;
		@(posedge core_clk_i) #1;
		`CHK("download", 1'b1, flash_download_o)
		`CHK("port", 1'b1, cfg_port_active_o)
		for (n = 0; n < 1000 && user_mode_o !== 1'b1; n++)
		begin
			@(posedge core_clk_i) src_req_i <= (n == 10);
			src_sel_i <= POCS_SRC_SLAVE_SERIAL;
			#1;
			if (user_mode_o !== 1'b1)
			begin
				`CHK("tristate", 1'b1, io_tristate_o)
				`CHK("src", POCS_SRC_FLASH, cfg_src_o)
				`CHK("bg_early", 1'b1, bandgap_on_o)
			end
		end
		`CHK("load_cyc", FLASH_DOWNLOAD_CYC + 1 + (bg ? CRC_CHECK_CYC + 1 : 0), n)
		`CHK("crc_ok", 1'b0, crc_error_o)
		`CHK("user", 1'b1, user_mode_o)
		`CHK("released", 1'b0, io_tristate_o)
		`CHK("user_rst", 1'b0, user_rst_o)
		repeat (2) @(posedge core_clk_i);
		#1;
		`CHK("port_done", 1'b0, cfg_port_active_o)
		`CHK("serial_gpio", 1'b1, serial_cfg_gpio_o)
		`CHK("bandgap", ~bg, bandgap_on_o)
		`CHK("precise", ~bg, precise_mon_on_o)
	endtask : power_up

	// Each trigger in turn, each with its own power-down options; wake-up outputs on the last
	task automatic standby();
		for (int k = 0; k < 3; k++)
		begin
			@(posedge core_clk_i) stby_i2c_i <= (k == 0);
			stby_jtag_i <= (k == 1);
			stby_pin_i <= stby_pin_i ^ (k == 2);
			wakeup_en_i <= (k == 2);
			monitor_off_on_stby_i <= (k != 1);
			bandgap_off_on_stby_i <= (k != 0);
			@(posedge core_clk_i) {stby_i2c_i, stby_jtag_i} <= 2'b00;
			#1;
			`CHK("stdby_out", (k == 2), cfg_stdby_o)
			repeat (2) @(posedge core_clk_i);
			#1;
			`CHK("stby", 1'b1, stby_o)
			`CHK("stby_user", 1'b1, user_mode_o)
			`CHK("stby_bg", (k == 0), bandgap_on_o)
			`CHK("stby_mon", 1'b0, precise_mon_on_o)
			@(posedge core_clk_i) wake_i <= 1'b1;
			@(posedge core_clk_i) wake_i <= 1'b0;
			#1;
			`CHK("wake_out", (k == 2), cfg_wake_o)
			repeat (2) @(posedge core_clk_i);
			#1;
			`CHK("woken", 1'b0, stby_o)
			`CHK("woken_pwr", 2'b11, {bandgap_on_o, precise_mon_on_o})
		end
	endtask : standby

	// One access pulse; grants are {readback, erase, program}
	task automatic req(logic [2:0] r, logic [2:0] g);
		@(posedge core_clk_i) {readback_req_i, erase_req_i, prog_req_i} <= r;
		@(posedge core_clk_i) {readback_req_i, erase_req_i, prog_req_i} <= 3'h0;
		#1;
		`CHK("grants", g, {readback_grant_o, erase_grant_o, prog_grant_o})
	endtask : req

	task automatic security();
		req(3'h4, 3'h4);
		@(posedge core_clk_i) sec_set_i <= 1'b1;
		@(posedge core_clk_i) sec_set_i <= 1'b0;
		req(3'h4, 3'h0);
		req(3'h1, 3'h1);
		`CHK("kept", 1'b1, sec_locked_o)
		req(3'h2, 3'h2);
		`CHK("erased", 1'b0, sec_locked_o)
		@(posedge core_clk_i) otp_set_i <= 1'b1;
		@(posedge core_clk_i) otp_set_i <= 1'b0;
		req(3'h2, 3'h0);
		req(3'h1, 3'h0);
	endtask : security

	task automatic tap_and_droop();
		@(posedge core_clk_i) jtag_activate_i <= 1'b1;
		test_port_select_i <= 1'b1;
		@(posedge core_clk_i) jtag_activate_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		#1;
		`CHK("jtag", 1'b1, jtag_active_o)
		`CHK("tap_pins", 1'b0, tap_gpio_o)
		@(posedge core_clk_i) test_port_select_i <= 1'b0;
		droop <= 1'b1;
		repeat (6) @(posedge core_clk_i);
		#1;
		`CHK("tap_gpio", 1'b1, tap_gpio_o)
		`CHK("no_watch", 1'b1, user_mode_o)
		@(posedge core_clk_i) monitor_keep_en_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1;
		`CHK("droop", 1'b0, user_mode_o)
		`CHK("retri", 1'b1, io_tristate_o)
		@(posedge core_clk_i) droop <= 1'b0;
		rails_up <= 1'b0;
	endtask : tap_and_droop

	// Low-power monitor droop, lagging outer rail on a regulated part, then a failing CRC
	task automatic crc_fail();
		@(posedge core_clk_i) droop <= 1'b1;
		crc_bad <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		droop <= 1'b0;
		regulated_variant_i <= 1'b1;
		ext_down <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1;
		`CHK("lp_droop", 1'b0, user_mode_o)
		`CHK("ext_hold", 1'b0, flash_download_o)
		@(posedge core_clk_i) ext_down <= 1'b0;
		repeat (600) @(posedge core_clk_i);
		#1;
		`CHK("crc_err", 1'b1, crc_error_o)
		`CHK("crc_user", 1'b0, user_mode_o)
		`CHK("crc_tri", 1'b1, io_tristate_o)
	endtask : crc_fail

	task automatic summarize();
		if (n_fail == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	// ****************************************
	// Clock, reset, sequence and watchdog
	// ****************************************
	initial
	begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	initial
	begin
		{rails_up, droop, regulated_variant_i, monitor_keep_en_i, crc_check_en_i} = '0;
		{ext_down, crc_bad} = '0;
		{wakeup_en_i, bandgap_off_on_stby_i, monitor_off_on_stby_i, bandgap_off_req_i} = '0;
		{stby_pin_i, stby_i2c_i, stby_jtag_i, wake_i, src_req_i, jtag_activate_i} = '0;
		{test_port_select_i, sec_set_i, otp_set_i, erase_req_i, prog_req_i} = '0;
		readback_req_i = 1'b0;
		src_sel_i = POCS_SRC_FLASH;
		rst_i = 1'b1;
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		#1;
		`CHK("rst_tri", 1'b1, io_tristate_o)
		power_up(1'b0);
		standby();
		security();
		tap_and_droop();
		power_up(1'b1);
		crc_fail();
		summarize();
	end

	// Whole run takes near 1750 cycles; allow many times that
	initial
	begin
		#(20000 * 4);
		n_fail++;
		summarize();
	end
endmodule : test_pocs_top
